// file: rtl/branch_exec_regs.vh
// constants for the branch and cpu-control execution block
`ifndef BRANCH_EXEC_REGS_VH
`define BRANCH_EXEC_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define REG_CTRL      5'h00
`define REG_INSTR     5'h04
`define REG_DISP      5'h08
`define REG_OPERAND   5'h0c
`define REG_PC        5'h10
`define REG_FLAGS     5'h14
`define REG_CORE      5'h18
`define REG_STATUS    5'h1c

// ************************************************************
// field positions
// ************************************************************
`define CTRL_START    0
`define CTRL_RELEASE  1
`define INSTR_AREA    12
`define ST_BUSY       0
`define ST_TAKEN      1
`define ST_HALTED     2
`define ST_ERROR      3
`define FW_CY         0
`define FW_RBS0       3
`define FW_AC         4
`define FW_RBS1       5
`define FW_Z          6
`define FW_IE         7

// ************************************************************
// reset values
// ************************************************************
`define PC_RST        16'h0000
`define FW_RST        8'h00

// ************************************************************
// operation codes
// ************************************************************
`define OP_NOP        5'h00
`define OP_JMP_ABS    5'h01
`define OP_JMP_REL    5'h02
`define OP_JMP_AX     5'h03
`define OP_BC         5'h04
`define OP_BNC        5'h05
`define OP_BZ         5'h06
`define OP_BNZ        5'h07
`define OP_BT_SADDR   5'h08
`define OP_BT_SFR     5'h09
`define OP_BT_A       5'h0a
`define OP_BT_PSW     5'h0b
`define OP_BT_HL      5'h0c
`define OP_BF_SADDR   5'h0d
`define OP_BF_SFR     5'h0e
`define OP_BF_A       5'h0f
`define OP_BF_PSW     5'h10
`define OP_BF_HL      5'h11
`define OP_TC_SADDR   5'h12
`define OP_TC_SFR     5'h13
`define OP_TC_A       5'h14
`define OP_TC_PSW     5'h15
`define OP_TC_HL      5'h16
`define OP_DB_B       5'h17
`define OP_DB_C       5'h18
`define OP_DB_SADDR   5'h19
`define OP_SEL        5'h1a
`define OP_EI         5'h1b
`define OP_DI         5'h1c
`define OP_HALT       5'h1d

// ************************************************************
// timing: {bytes, clocks fast area, clocks other area}, 0 = none
// ************************************************************
`define TM_NOP        12'h120
`define TM_JMP_ABS    12'h360
`define TM_JMP_REL    12'h260
`define TM_JMP_AX     12'h280
`define TM_COND       12'h260
`define TM_BT_SADDR   12'h389
`define TM_BT_SFR     12'h40b
`define TM_BT_A       12'h380
`define TM_BT_PSW     12'h309
`define TM_BT_HL      12'h3ab
`define TM_BF_SADDR   12'h4ab
`define TM_BF_SFR     12'h40b
`define TM_BF_A       12'h380
`define TM_BF_PSW     12'h40b
`define TM_BF_HL      12'h3ab
`define TM_TC_SADDR   12'h4ac
`define TM_TC_SFR     12'h40c
`define TM_TC_A       12'h380
`define TM_TC_PSW     12'h40c
`define TM_TC_HL      12'h3ac
`define TM_DB_R       12'h260
`define TM_DB_SADDR   12'h38a
`define TM_SEL        12'h240
`define TM_EI_DI      12'h206
`define TM_HALT       12'h260

`endif

// file: rtl/rel_target.v
// relative branch target adder
`timescale 1ns/10ps
`default_nettype none

module rel_target (
  input  wire [15:0] pc_i,
  input  wire [3:0]  len_i,
  input  wire [7:0]  disp_i,
  output wire [15:0] target_o
);

  // ************************************************************
  // pc plus length plus signed displacement
  // ************************************************************
  assign target_o = pc_i + {12'h000, len_i} + {{8{disp_i[7]}}, disp_i};

endmodule

`default_nettype wire

// file: rtl/cycle_timer.v
// down counter that holds the core busy for an instruction's clocks
`timescale 1ns/10ps
`default_nettype none

module cycle_timer (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       load_i,
  input  wire [3:0] count_i,
  output wire       busy_o
);

  reg [3:0] remain;

  // ************************************************************
  // counter
  // ************************************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      remain <= 4'h0;
    end else if (ce_i) begin
      if (load_i) begin
        remain <= count_i;
      end else if (remain != 4'h0) begin
        remain <= remain - 4'h1;
      end
    end
  end

  assign busy_o = (remain != 4'h0);

endmodule

`default_nettype wire

// file: rtl/branch_cpu_control_exec.v
// execution unit for branch and cpu-control instructions
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "branch_exec_regs.vh"

module branch_cpu_control_exec (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire [4:0]  address_i,
  input  wire        read_i,
  input  wire        write_i,
  input  wire [31:0] writedata_i,
  input  wire [3:0]  byteenable_i,
  output reg  [31:0] readdata_o,
  output reg         waitrequest_o,
  output reg  [15:0] pc_o,
  output reg  [7:0]  flag_word_o,
  output reg         halted_o
);

  // ************************************************************
  // state
  // ************************************************************
  reg  [4:0]  instr_op;
  reg  [2:0]  instr_bit;
  reg         instr_area;
  reg  [15:0] disp;
  reg  [7:0]  operand;
  reg  [7:0]  acc_a;
  reg  [7:0]  reg_x;
  reg  [7:0]  reg_b;
  reg  [7:0]  reg_c;
  reg         exec_pend;
  reg         taken;
  reg         error;
  reg  [3:0]  last_len;
  reg  [3:0]  last_clk;

  // ************************************************************
  // decode results
  // ************************************************************
  reg  [11:0] tm;
  reg  [3:0]  clocks;
  reg  [15:0] next_pc;
  reg  [7:0]  next_fw;
  reg  [7:0]  next_operand;
  reg  [7:0]  next_b;
  reg  [7:0]  next_c;
  reg         next_halt;
  reg         next_taken;
  reg         cond;
  reg         rel;
  reg  [31:0] rd_mux;
  reg  [31:0] wmask;

  wire [15:0] target;
  wire        timer_busy;
  wire        busy;
  wire        req;
  wire        wr_do;
  wire [7:0]  bit_mask;
  wire        bit_opnd;
  wire        bit_a;
  wire        bit_fw;
  wire [7:0]  dec_b;
  wire [7:0]  dec_c;
  wire [7:0]  dec_opnd;
  wire        start_ok;

  // ************************************************************
  // timing table
  // ************************************************************
  function [11:0] timing;
    input [4:0] op;
    begin
      case (op)
        `OP_NOP:      timing = `TM_NOP;
        `OP_JMP_ABS:  timing = `TM_JMP_ABS;
        `OP_JMP_REL:  timing = `TM_JMP_REL;
        `OP_JMP_AX:   timing = `TM_JMP_AX;
        `OP_BC:       timing = `TM_COND;
        `OP_BNC:      timing = `TM_COND;
        `OP_BZ:       timing = `TM_COND;
        `OP_BNZ:      timing = `TM_COND;
        `OP_BT_SADDR: timing = `TM_BT_SADDR;
        `OP_BT_SFR:   timing = `TM_BT_SFR;
        `OP_BT_A:     timing = `TM_BT_A;
        `OP_BT_PSW:   timing = `TM_BT_PSW;
        `OP_BT_HL:    timing = `TM_BT_HL;
        `OP_BF_SADDR: timing = `TM_BF_SADDR;
        `OP_BF_SFR:   timing = `TM_BF_SFR;
        `OP_BF_A:     timing = `TM_BF_A;
        `OP_BF_PSW:   timing = `TM_BF_PSW;
        `OP_BF_HL:    timing = `TM_BF_HL;
        `OP_TC_SADDR: timing = `TM_TC_SADDR;
        `OP_TC_SFR:   timing = `TM_TC_SFR;
        `OP_TC_A:     timing = `TM_TC_A;
        `OP_TC_PSW:   timing = `TM_TC_PSW;
        `OP_TC_HL:    timing = `TM_TC_HL;
        `OP_DB_B:     timing = `TM_DB_R;
        `OP_DB_C:     timing = `TM_DB_R;
        `OP_DB_SADDR: timing = `TM_DB_SADDR;
        `OP_SEL:      timing = `TM_SEL;
        `OP_EI:       timing = `TM_EI_DI;
        `OP_DI:       timing = `TM_EI_DI;
        `OP_HALT:     timing = `TM_HALT;
        default:      timing = 12'h000;
      endcase
    end
  endfunction

  // ************************************************************
  // operand bits and helpers
  // ************************************************************
  assign bit_mask = 8'h01 << instr_bit;
  assign bit_opnd = operand[instr_bit];
  assign bit_a    = acc_a[instr_bit];
  assign bit_fw   = flag_word_o[instr_bit];
  assign dec_b    = reg_b - 8'h01;
  assign dec_c    = reg_c - 8'h01;
  assign dec_opnd = operand - 8'h01;
  assign busy     = exec_pend | timer_busy;
  assign req      = read_i | write_i;
  assign wr_do    = write_i & ~waitrequest_o;
  assign start_ok = wr_do & (address_i == `REG_CTRL) & byteenable_i[0]
                  & writedata_i[`CTRL_START] & ~halted_o;

  rel_target u_target (
    .pc_i     (pc_o),
    .len_i    (tm[11:8]),
    .disp_i   (disp[7:0]),
    .target_o (target)
  );

  cycle_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .load_i    (exec_pend),
    .count_i   (clocks - 4'h1),
    .busy_o    (timer_busy)
  );

  // ************************************************************
  // clock figure selection
  // ************************************************************
  always @* begin
    tm = timing(instr_op);
    if ((instr_area && (tm[3:0] != 4'h0)) || (tm[7:4] == 4'h0)) begin
      clocks = tm[3:0];
    end else begin
      clocks = tm[7:4];
    end
  end

  // ************************************************************
  // instruction execution
  // ************************************************************
  always @* begin
    next_pc      = pc_o;
    next_fw      = flag_word_o;
    next_operand = operand;
    next_b       = reg_b;
    next_c       = reg_c;
    next_halt    = halted_o;
    cond         = 1'b0;
    rel          = 1'b1;
    case (instr_op)
      `OP_NOP: begin
        rel = 1'b0;
      end
      `OP_JMP_ABS: begin
        rel     = 1'b0;
        cond    = 1'b1;
        next_pc = disp;
      end
      `OP_JMP_REL: cond = 1'b1;
      `OP_JMP_AX: begin
        rel     = 1'b0;
        cond    = 1'b1;
        next_pc = {acc_a, reg_x};
      end
      `OP_BC:       cond = flag_word_o[`FW_CY];
      `OP_BNC:      cond = ~flag_word_o[`FW_CY];
      `OP_BZ:       cond = flag_word_o[`FW_Z];
      `OP_BNZ:      cond = ~flag_word_o[`FW_Z];
      `OP_BT_SADDR: cond = bit_opnd;
      `OP_BT_SFR:   cond = bit_opnd;
      `OP_BT_A:     cond = bit_a;
      `OP_BT_PSW:   cond = bit_fw;
      `OP_BT_HL:    cond = bit_opnd;
      `OP_BF_SADDR: cond = ~bit_opnd;
      `OP_BF_SFR:   cond = ~bit_opnd;
      `OP_BF_A:     cond = ~bit_a;
      `OP_BF_PSW:   cond = ~bit_fw;
      `OP_BF_HL:    cond = ~bit_opnd;
      `OP_TC_SADDR, `OP_TC_SFR, `OP_TC_HL: begin
        cond = bit_opnd;
        if (bit_opnd) begin
          next_operand = operand & ~bit_mask;
        end
      end
      `OP_TC_A: begin
        cond = bit_a;
      end
      `OP_TC_PSW: begin
        cond = bit_fw;
        if (bit_fw) begin
          next_fw = flag_word_o & ~bit_mask;
        end
      end
      `OP_DB_B: begin
        next_b = dec_b;
        cond   = (dec_b != 8'h00);
      end
      `OP_DB_C: begin
        next_c = dec_c;
        cond   = (dec_c != 8'h00);
      end
      `OP_DB_SADDR: begin
        next_operand = dec_opnd;
        cond         = (dec_opnd != 8'h00);
      end
      `OP_SEL: begin
        rel                = 1'b0;
        next_fw[`FW_RBS1]  = instr_bit[1];
        next_fw[`FW_RBS0]  = instr_bit[0];
      end
      `OP_EI: begin
        rel              = 1'b0;
        next_fw[`FW_IE]  = 1'b1;
      end
      `OP_DI: begin
        rel              = 1'b0;
        next_fw[`FW_IE]  = 1'b0;
      end
      `OP_HALT: begin
        rel       = 1'b0;
        next_halt = 1'b1;
      end
      default: begin
        rel = 1'b0;
      end
    endcase
    if (rel && cond) begin
      next_pc = target;
    end
    next_taken = cond;
  end

  // ************************************************************
  // bus read mux and write mask
  // ************************************************************
  always @* begin
    wmask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}}, {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
    case (address_i)
      `REG_CTRL:    rd_mux = 32'h0000_0000;
      `REG_INSTR:   rd_mux = {19'h00000, instr_area, 1'b0, instr_bit, 3'h0, instr_op};
      `REG_DISP:    rd_mux = {16'h0000, disp};
      `REG_OPERAND: rd_mux = {24'h000000, operand};
      `REG_PC:      rd_mux = {16'h0000, pc_o};
      `REG_FLAGS:   rd_mux = {24'h000000, flag_word_o};
      `REG_CORE:    rd_mux = {reg_c, reg_b, reg_x, acc_a};
      `REG_STATUS:  rd_mux = {16'h0000, last_clk, last_len, 4'h0,
                              error, halted_o, taken, busy};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // avalon handshake: one wait cycle, writes stall while busy
  // ************************************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h0000_0000;
    end else if (ce_i) begin
      if (req && waitrequest_o && !(write_i && busy)) begin
        waitrequest_o <= 1'b0;
        readdata_o    <= read_i ? rd_mux : 32'h0000_0000;
      end else begin
        waitrequest_o <= 1'b1;
      end
    end
  end

  // ************************************************************
  // register writes and commit of an executed instruction
  // ************************************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      instr_op    <= `OP_NOP;
      instr_bit   <= 3'h0;
      instr_area  <= 1'b0;
      disp        <= 16'h0000;
      operand     <= 8'h00;
      acc_a       <= 8'h00;
      reg_x       <= 8'h00;
      reg_b       <= 8'h00;
      reg_c       <= 8'h00;
      pc_o        <= `PC_RST;
      flag_word_o <= `FW_RST;
      halted_o    <= 1'b0;
      exec_pend   <= 1'b0;
      taken       <= 1'b0;
      error       <= 1'b0;
      last_len    <= 4'h0;
      last_clk    <= 4'h0;
    end else if (ce_i) begin
      exec_pend <= start_ok;
      if (exec_pend) begin
        last_len <= tm[11:8];
        last_clk <= clocks;
        if (tm == 12'h000) begin
          error <= 1'b1;
          taken <= 1'b0;
        end else begin
          error       <= 1'b0;
          taken       <= next_taken;
          pc_o        <= next_pc;
          flag_word_o <= next_fw;
          operand     <= next_operand;
          reg_b       <= next_b;
          reg_c       <= next_c;
          halted_o    <= next_halt;
        end
      end else if (wr_do) begin
        case (address_i)
          `REG_CTRL: begin
            if (byteenable_i[0] && writedata_i[`CTRL_RELEASE]) begin
              halted_o <= 1'b0;
            end
          end
          `REG_INSTR: begin
            if (byteenable_i[0]) begin
              instr_op <= writedata_i[4:0];
            end
            if (byteenable_i[1]) begin
              instr_bit  <= writedata_i[10:8];
              instr_area <= writedata_i[`INSTR_AREA];
            end
          end
          `REG_DISP: begin
            disp <= (disp & ~wmask[15:0]) | (writedata_i[15:0] & wmask[15:0]);
          end
          `REG_OPERAND: begin
            if (byteenable_i[0]) begin
              operand <= writedata_i[7:0];
            end
          end
          `REG_PC: begin
            pc_o <= (pc_o & ~wmask[15:0]) | (writedata_i[15:0] & wmask[15:0]);
          end
          `REG_FLAGS: begin
            if (byteenable_i[0]) begin
              flag_word_o <= writedata_i[7:0];
            end
          end
          `REG_CORE: begin
            if (byteenable_i[0]) begin
              acc_a <= writedata_i[7:0];
            end
            if (byteenable_i[1]) begin
              reg_x <= writedata_i[15:8];
            end
            if (byteenable_i[2]) begin
              reg_b <= writedata_i[23:16];
            end
            if (byteenable_i[3]) begin
              reg_c <= writedata_i[31:24];
            end
          end
          default: begin
            taken <= taken;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/branch_exec_checker.sv
// assertion checker for the branch execution block
`timescale 1ns/10ps
`default_nettype none
`include "branch_exec_regs.vh"
module branch_exec_checker (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [4:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0]  flag_word_o,
  input wire logic        halted_o
);
  // ************************************************************
  // accepted accesses
  // ************************************************************
  logic       acc;
  logic       ctl;
  logic       go;
  logic       rel;
  logic       pc_wr;
  logic       fw_wr;
  logic [4:0] op_q;
  logic [1:0] bank_q;
  assign acc   = write_i && !waitrequest_o && ce_i;
  assign ctl   = acc && address_i == `REG_CTRL && byteenable_i[0];
  assign go    = ctl && writedata_i[`CTRL_START] && !halted_o;
  assign rel   = ctl && writedata_i[`CTRL_RELEASE];
  assign pc_wr = acc && address_i == `REG_PC;
  assign fw_wr = acc && address_i == `REG_FLAGS;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_q   <= `OP_NOP;
      bank_q <= 2'h0;
    end else if (acc && address_i == `REG_INSTR && byteenable_i[1:0] == 2'h3) begin
      op_q   <= writedata_i[4:0];
      bank_q <= writedata_i[9:8];
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // ************************************************************
  // assertions
  // ************************************************************
  wait_pulse_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  read_answer_a: assert property (read_i && waitrequest_o && ce_i |=> !waitrequest_o)
    else $error("read not answered in the next cycle");
  unmapped_zero_a: assert property (read_i && !waitrequest_o && address_i[1:0] != 2'h0 |-> readdata_o == 32'h0)
    else $error("unmapped read returned nonzero data");
  pc_source_a: assert property ($changed(pc_o) |-> $past(rst_i) || $past(pc_wr) || $past(go, 2))
    else $error("program counter changed without a cause");
  flag_source_a: assert property ($changed(flag_word_o) |-> $past(rst_i) || $past(fw_wr) || $past(go, 2))
    else $error("flag word changed without a cause");
  halt_enter_a: assert property ($rose(halted_o) |-> $past(go, 2))
    else $error("halt entered without an executed instruction");
  halt_release_a: assert property ($fell(halted_o) |-> $past(rst_i) || $past(rel))
    else $error("halt left without a release write");
  ie_set_a: assert property (go && op_q == `OP_EI |-> ##2 flag_word_o[`FW_IE])
    else $error("interrupt enable not set");
  ie_clear_a: assert property (go && op_q == `OP_DI |-> ##2 !flag_word_o[`FW_IE])
    else $error("interrupt enable not cleared");
  bank_sel_a: assert property (go && op_q == `OP_SEL |-> ##2 {flag_word_o[`FW_RBS1], flag_word_o[`FW_RBS0]} == bank_q)
    else $error("bank select bits wrong");
endmodule
bind branch_cpu_control_exec branch_exec_checker u_chk (.clk_sys_i, .rst_i, .ce_i, .address_i, .read_i, .write_i,
  .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o, .pc_o, .flag_word_o, .halted_o);
`default_nettype wire

// file: tb/tb_branch_cpu_control_exec.sv
// self-checking bench for the branch execution block
`timescale 1ns/10ps
`default_nettype none
`include "branch_exec_regs.vh"
module tb_branch_cpu_control_exec;
  logic        clk_sys_i;
  logic        rst_i;
  logic        ce_i;
  logic [4:0]  address_i;
  logic        read_i;
  logic        write_i;
  logic [31:0] writedata_i;
  logic [3:0]  byteenable_i;
  wire  [31:0] readdata_o;
  wire         waitrequest_o;
  wire  [15:0] pc_o;
  wire  [7:0]  flag_word_o;
  wire         halted_o;
  int          n_fail;
  int          total_checks;
  logic [31:0] rd;
  logic [31:0] st;
  logic [11:0] tab [15];
  branch_cpu_control_exec u_dut (.clk_sys_i, .rst_i, .ce_i, .address_i, .read_i, .write_i, .writedata_i,
    .byteenable_i, .readdata_o, .waitrequest_o, .pc_o, .flag_word_o, .halted_o);
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    address_i   <= a;
    writedata_i <= d;
    write_i     <= wr;
    read_i      <= !wr;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_fail++;
      close_out();
    end
    rd = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
  endtask
  task automatic start_op(input logic [4:0] op, input logic [2:0] idx, input logic area, input logic [15:0] disp,
                          input logic [7:0] opnd, input logic [15:0] pc, input logic [7:0] fw, input logic [31:0] core);
    bus(1'b1, `REG_PC, {16'h0, pc});
    bus(1'b1, `REG_FLAGS, {24'h0, fw});
    bus(1'b1, `REG_DISP, {16'h0, disp});
    bus(1'b1, `REG_OPERAND, {24'h0, opnd});
    bus(1'b1, `REG_CORE, core);
    bus(1'b1, `REG_INSTR, {19'h0, area, 1'b0, idx, 3'h0, op});
    bus(1'b1, `REG_CTRL, 32'h1);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      bus(1'b0, `REG_STATUS, 32'h0);
      n++;
    end while (rd[`ST_BUSY] !== 1'b0 && n < 40);
    if (rd[`ST_BUSY] !== 1'b0) begin
      n_fail++;
      close_out();
    end
    st = rd;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset;
    chk({pc_o, flag_word_o, 6'h0, halted_o, waitrequest_o}, 32'h1);
    bus(1'b1, 5'h11, 32'hffff_ffff);
    bus(1'b0, `REG_PC, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 5'h02, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic test_cond;
    logic f;
    logic tk;
    for (int i = 0; i < 8; i++) begin
      f = i[0];
      tk = f ^ i[1];
      start_op(`OP_BC + i[2:1], 3'h0, f, 16'h00f0, 8'h0, 16'h1000, f ? 8'h41 : 8'h00, 32'h0);
      wait_done();
      chk(st[15:8], 8'h62);
      chk(st[`ST_TAKEN], tk);
      if (tk) chk({16'h0, pc_o}, 32'h0ff2);
      else chk({16'h0, pc_o}, 32'h1000);
    end
    $display("test cond done");
  endtask
  task automatic test_bits;
    int g;
    int m;
    logic v;
    logic tk;
    logic [7:0] opnd;
    logic [7:0] fw;
    for (int i = 0; i < 15; i++) begin
      for (int b = 0; b < 2; b++) begin
        g = i / 5;
        m = i % 5;
        v = b[0];
        tk = (g == 1) ? !v : v;
        opnd = v ? 8'ha5 : 8'h85;
        fw = v ? 8'h41 : 8'h40;
        start_op(5'h08 + i[4:0], (m == 3) ? 3'h0 : 3'h5, v, 16'h0010, opnd, 16'h2000, fw, {24'h0, opnd});
        wait_done();
        chk(st[15:8], {v ? tab[i][3:0] : tab[i][7:4], tab[i][11:8]});
        chk(st[`ST_TAKEN], tk);
        if (tk) chk({16'h0, pc_o}, 32'h2010 + tab[i][11:8]);
        else chk({16'h0, pc_o}, 32'h2000);
        bus(1'b0, `REG_OPERAND, 32'h0);
        chk(rd[7:0], (g == 2 && tk && m != 2 && m != 3) ? 8'h85 : opnd);
        if (m == 3) chk(flag_word_o, (g == 2 && tk) ? 8'h40 : fw);
      end
    end
    $display("test bits done");
  endtask
  task automatic test_dec;
    start_op(`OP_DB_B, 3'h0, 1'b0, 16'h0008, 8'h0, 16'h3000, 8'h0, 32'h0001_0000);
    wait_done();
    chk(st[15:8], 8'h62);
    chk(st[`ST_TAKEN], 1'b0);
    bus(1'b0, `REG_CORE, 32'h0);
    chk(rd, 32'h0);
    start_op(`OP_DB_C, 3'h0, 1'b0, 16'h0008, 8'h0, 16'h3000, 8'h0, 32'h0);
    wait_done();
    chk({16'h0, pc_o}, 32'h300a);
    bus(1'b0, `REG_CORE, 32'h0);
    chk(rd, 32'hff00_0000);
    start_op(`OP_DB_SADDR, 3'h0, 1'b1, 16'h0008, 8'h02, 16'h3000, 8'h0, 32'h0);
    wait_done();
    chk({st[15:8], pc_o}, 32'ha3_300b);
    bus(1'b0, `REG_OPERAND, 32'h0);
    chk(rd, 32'h1);
    $display("test dec done");
  endtask
  task automatic test_jump;
    start_op(`OP_JMP_ABS, 3'h0, 1'b0, 16'h8765, 8'h0, 16'h0, 8'h0, 32'h0);
    bus(1'b0, `REG_PC, 32'h0);
    chk(rd, 32'h8765);
    bus(1'b1, `REG_PC, 32'h5555);
    wait_done();
    chk({st[15:8], pc_o}, 32'h63_5555);
    start_op(`OP_JMP_REL, 3'h0, 1'b0, 16'h007f, 8'h0, 16'hfff0, 8'h0, 32'h0);
    wait_done();
    chk({st[15:8], pc_o}, 32'h62_0071);
    start_op(`OP_JMP_AX, 3'h0, 1'b1, 16'h0, 8'h0, 16'h0, 8'h0, 32'h0000_3412);
    wait_done();
    chk({st[15:8], pc_o}, 32'h82_1234);
    $display("test jump done");
  endtask
  task automatic test_ctrl;
    start_op(`OP_NOP, 3'h0, 1'b0, 16'h0, 8'h0, 16'h0, 8'h55, 32'h0);
    wait_done();
    chk({st[15:8], flag_word_o}, 32'h21_55);
    start_op(`OP_SEL, 3'h2, 1'b0, 16'h0, 8'h0, 16'h0, 8'h00, 32'h0);
    wait_done();
    chk({st[15:8], flag_word_o}, 32'h42_20);
    start_op(`OP_SEL, 3'h1, 1'b0, 16'h0, 8'h0, 16'h0, 8'hff, 32'h0);
    wait_done();
    chk(flag_word_o, 8'hdf);
    start_op(`OP_EI, 3'h0, 1'b0, 16'h0, 8'h0, 16'h0, 8'h00, 32'h0);
    wait_done();
    chk({st[15:8], flag_word_o}, 32'h62_80);
    start_op(`OP_DI, 3'h0, 1'b1, 16'h0, 8'h0, 16'h0, 8'hff, 32'h0);
    wait_done();
    chk({st[15:8], flag_word_o}, 32'h62_7f);
    start_op(`OP_HALT, 3'h0, 1'b0, 16'h0, 8'h0, 16'h0, 8'h00, 32'h0);
    wait_done();
    chk({st[15:8], 7'h0, halted_o}, 16'h6201);
    chk(st[`ST_HALTED], 1'b1);
    start_op(`OP_JMP_ABS, 3'h0, 1'b0, 16'h4444, 8'h0, 16'h0, 8'h0, 32'h0);
    bus(1'b0, `REG_PC, 32'h0);
    chk(rd, 32'h0);
    chk({16'h0, pc_o}, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h2);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(halted_o, 1'b0);
    start_op(5'h1e, 3'h0, 1'b0, 16'h0, 8'h0, 16'h0, 8'h0, 32'h0);
    wait_done();
    chk(st[`ST_ERROR], 1'b1);
    $display("test ctrl done");
  endtask
  initial begin
    n_fail = 0;
    total_checks = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    address_i = 5'h0;
    read_i = 1'b0;
    write_i = 1'b0;
    writedata_i = 32'h0;
    byteenable_i = 4'hf;
    tab = '{12'h389, 12'h4bb, 12'h388, 12'h399, 12'h3ab, 12'h4ab, 12'h4bb, 12'h388,
            12'h4bb, 12'h3ab, 12'h4ac, 12'h4cc, 12'h388, 12'h4cc, 12'h3ac};
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    test_reset();
    test_cond();
    test_bits();
    test_dec();
    test_jump();
    test_ctrl();
    close_out();
  end
endmodule
`default_nettype wire
